// *** src/asmc_bit_reg.sv ***
`timescale 1ns/1ps
// one writable control bit with its own write-enable
module asmc_bit_reg #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    input  wire logic i_we,
    input  wire logic i_d,
    output logic      o_q
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_q <= RESET_VAL;
        end else if (i_ce && i_we) begin
            o_q <= i_d;
        end
    end
endmodule

// *** src/asmc_defines.svh ***
`ifndef ASMC_DEFINES_SVH
`define ASMC_DEFINES_SVH

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define ASMC_MODE_ADDR     16'hff70
`define ASMC_MODE_RESET    8'h01
`define ASMC_BIT_POWER     7
`define ASMC_BIT_TXEN      6
`define ASMC_BIT_RXEN      5
`define ASMC_BIT_FIXED     0
`define ASMC_WMASK         8'hfe

`endif

// *** src/asmc_pkg.sv ***
package asmc_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic unit_power_enable;
        logic transmit_enable_bit;
        logic receive_enable_bit;
    } asmc_ctrl_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  wmask;
        logic        wr;
        logic        rd;
    } asmc_bus_t;

    typedef enum logic [1:0] {
        ASMC_OFF,
        ASMC_IDLE,
        ASMC_ACTIVE
    } asmc_state_t;

endpackage

// *** src/asmc_top.sv ***
`timescale 1ns/1ps
`include "asmc_defines.svh"
// Notes on behaviour
// - Any reset loads the mode register with 01h, all three enables clear.
// - Bit writes and byte writes both work, each bit changing on its own.
// - Power bit clear gates the unit clock low and resets the serial circuit.
// - Power bit clear holds error flags, shift register and buffer in reset.
// - Power bit clear forces the receive pin input high inside.
// - Transmit enable clear stops and synchronously resets transmission.
// - Receive enable clear stops and synchronously resets reception.
module asmc_top
    import asmc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  i_wmask,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_serial_receive_pin,
    output logic      [7:0]  o_rdata,
    output logic             o_unit_clk_en,
    output logic             o_unit_rstn,
    output logic             o_tx_rstn,
    output logic             o_rx_rstn,
    output logic             o_tx_enable,
    output logic             o_rx_enable,
    output logic             o_rx_pin_int,
    output logic      [1:0]  o_state
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic       hit    = (i_addr == `ASMC_MODE_ADDR);
    wire logic       wr_hit = i_wr && hit;
    // per-bit enable so a one-bit manipulation leaves the others
    // bitwise write mask
    wire logic [7:0] bit_we = {8{wr_hit}} & i_wmask & `ASMC_WMASK;
    // reset image as a constant, so that each bit register takes its own bit
    localparam logic [7:0] RST_V = `ASMC_MODE_RESET;

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    genvar g;
    generate
        for (g = 1; g < 8; g++) begin : g_bits
            asmc_bit_reg #(.RESET_VAL(RST_V[g])) u_bit (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_ce   (i_ce),
                .i_we   (bit_we[g]),
                .i_d    (i_wdata[g]),
                .o_q    (mode_q[g])
            );
        end
    endgenerate
    assign mode_q[`ASMC_BIT_FIXED] = 1'b1;

    asmc_ctrl_t ctrl;
    assign ctrl.unit_power_enable   = mode_q[`ASMC_BIT_POWER];
    assign ctrl.transmit_enable_bit = mode_q[`ASMC_BIT_TXEN];
    assign ctrl.receive_enable_bit  = mode_q[`ASMC_BIT_RXEN];

    // ------------------------------------------------------------
    // unit controls
    // ------------------------------------------------------------
    // clock gate and async reset
    assign o_unit_clk_en = ctrl.unit_power_enable;
    assign o_unit_rstn   = i_rstn & ctrl.unit_power_enable;
    assign o_tx_enable   = ctrl.unit_power_enable & ctrl.transmit_enable_bit;
    assign o_tx_rstn     = o_tx_enable;
    assign o_rx_enable   = ctrl.unit_power_enable & ctrl.receive_enable_bit;
    assign o_rx_rstn     = o_rx_enable;
    assign o_rx_pin_int  = i_serial_receive_pin | ~ctrl.unit_power_enable;

    // ------------------------------------------------------------
    // read path and state
    // ------------------------------------------------------------
    logic [7:0]  rdata_q;
    asmc_state_t state_q;
    wire asmc_state_t state_d = !ctrl.unit_power_enable ? ASMC_OFF :
        (o_tx_enable | o_rx_enable) ? ASMC_ACTIVE : ASMC_IDLE;
    // unmapped reads return zero
    wire logic [7:0] rdata_d = (i_rd && hit) ? mode_q : 8'h00;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 8'h00;
            state_q <= ASMC_OFF;
        end else if (i_ce) begin
            rdata_q <= rdata_d;
            state_q <= state_d;
        end
    end
    assign o_rdata = rdata_q;
    always_comb begin
        case (state_q)
            ASMC_OFF:    o_state = 2'h0;
            ASMC_IDLE:   o_state = 2'h1;
            ASMC_ACTIVE: o_state = 2'h2;
            default:     o_state = 2'h0;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // strobes as the register sees them, clock enable included
    wire logic       wr_take = i_ce && wr_hit;
    wire logic       rd_take = i_ce && i_rd && hit;
    // bits a write may move; bit 0 is never among them
    wire logic [7:0] wr_bits = i_wmask & `ASMC_WMASK;

    // ------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------
    // no disable here, so the reset period itself is covered
    reset_value_a: assert property (@(posedge i_clk)
        $rose(i_rstn) |-> mode_q == 8'h01)
        else $error("mode register not 01h after reset");
    reset_outputs_a: assert property (@(posedge i_clk)
        !i_rstn |-> mode_q == 8'h01 && o_rdata == 8'h00 && o_state == 2'h0 && !o_unit_rstn)
        else $error("outputs not at reset values during reset");

    // ------------------------------------------------------------
    // write checks
    // ------------------------------------------------------------
    // the mask decides which bits move; everything else must hold
    bit_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && i_wmask == 8'h80) |=> mode_q[6:0] == $past(mode_q[6:0]))
        else $error("single bit write disturbed other bits");
    byte_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && i_wmask == 8'hff) |=> mode_q == {$past(i_wdata[7:1]), 1'b1})
        else $error("byte write did not land");
    write_lands_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_take |=> ((mode_q ^ $past(i_wdata)) & $past(wr_bits)) == 8'h00)
        else $error("masked bit did not take the written value");
    masked_bits_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_take |=> ((mode_q ^ $past(mode_q)) & ~$past(wr_bits)) == 8'h00)
        else $error("unmasked bit changed on write");
    other_addr_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_wr && !hit) |=> mode_q == $past(mode_q))
        else $error("write to another address changed the register");
    // a low clock enable freezes every stored bit
    ce_freeze_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_ce |=> mode_q == $past(mode_q) && o_rdata == $past(o_rdata)
            && o_state == $past(o_state))
        else $error("state moved while clock enable low");

    // ------------------------------------------------------------
    // read checks
    // ------------------------------------------------------------
    // read data stand for one enabled cycle only and are zero otherwise
    read_data_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rd_take |=> o_rdata == $past(mode_q))
        else $error("read data differ from register");
    fixed_one_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rd_take |=> o_rdata[0])
        else $error("bit 0 read back as zero");
    unmapped_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_rd && !hit) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    idle_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_rd) |=> o_rdata == 8'h00)
        else $error("read data stood longer than one cycle");

    // ------------------------------------------------------------
    // unit control checks
    // ------------------------------------------------------------
    // these outputs are combinational, so they must agree in every cycle
    clock_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !mode_q[7] |-> !o_unit_clk_en && !o_unit_rstn)
        else $error("unit clock or reset wrong with power off");
    power_on_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && wr_bits[7] && i_wdata[7]) |=> o_unit_clk_en && o_unit_rstn)
        else $error("unit clock not running after power on");
    hold_reset_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !mode_q[7] |-> !o_unit_rstn && !o_tx_rstn && !o_rx_rstn)
        else $error("unit not held in reset");
    pin_force_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !o_unit_clk_en |-> o_rx_pin_int)
        else $error("receive input not forced high");
    pin_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_unit_clk_en |-> o_rx_pin_int == i_serial_receive_pin)
        else $error("receive input does not follow pin");
    tx_enable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && wr_bits[6] && !i_wdata[6]) |=> !o_tx_enable)
        else $error("transmit not disabled after write");
    tx_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && wr_bits[6] && i_wdata[6]) |=> o_tx_enable == mode_q[7])
        else $error("transmit enable wrong after set");
    tx_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !mode_q[6] |-> !o_tx_enable && !o_tx_rstn)
        else $error("transmit not held in reset");
    rx_enable_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && wr_bits[5] && !i_wdata[5]) |=> !o_rx_enable)
        else $error("receive not disabled after write");
    rx_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (wr_take && wr_bits[5] && i_wdata[5]) |=> o_rx_enable == mode_q[7])
        else $error("receive enable wrong after set");
    rx_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !mode_q[5] |-> !o_rx_enable && !o_rx_rstn)
        else $error("receive not held in reset");

    // ------------------------------------------------------------
    // state checks
    // ------------------------------------------------------------
    // state lags the register by one enabled edge
    state_off_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !mode_q[7]) |=> o_state == 2'h0)
        else $error("state not off with power clear");
    state_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && mode_q[7] && !mode_q[6] && !mode_q[5]) |=> o_state == 2'h1)
        else $error("state not idle with both enables clear");
    state_active_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && (o_tx_enable || o_rx_enable)) |=> o_state == 2'h2)
        else $error("state not active with an enable set");
endmodule

// *** verification/asmc_remote_tx.sv ***
`timescale 1ns/1ps
// far-end transmitter: one bit per clock keeps frames short
module asmc_remote_tx (
    input  wire logic       i_clk,
    input  wire logic       i_send,
    input  wire logic [7:0] i_byte,
    output logic            o_line
);
    logic [9:0] sh_q = 10'h3ff;
    // start low, data lsb first, stop high; ones shift in so the line idles high
    always @(posedge i_clk) begin
        if (i_send) sh_q <= {1'b1, i_byte, 1'b0};
        else sh_q <= {1'b1, sh_q[9:1]};
    end
    assign o_line = sh_q[0];
endmodule

// *** verification/asmc_top_tb_top.sv ***
`timescale 1ns/1ps
`include "asmc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module asmc_top_tb_top;
    logic        i_clk = 1'b0, i_rstn, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic        send = 1'b0, pend = 1'b0;
    logic        o_unit_clk_en, o_unit_rstn, o_tx_rstn, o_rx_rstn, pin, lo;
    logic        o_tx_enable, o_rx_enable, o_rx_pin_int;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0]  i_wdata = 8'h00, i_wmask = 8'h00, o_rdata, mdl = 8'h01, tx_byte = 8'h00, exp_v;
    logic [1:0]  o_state;
    logic [7:0]  exp_q[$];
    int          num_errors = 0, comparisons = 0;
    localparam logic [15:0] AD = `ASMC_MODE_ADDR;
    always #5 i_clk = ~i_clk;
    asmc_remote_tx u_far (.i_clk(i_clk), .i_send(send), .i_byte(tx_byte), .o_line(pin));
    asmc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wmask(i_wmask), .i_wr(i_wr), .i_rd(i_rd),
        .i_serial_receive_pin(pin), .o_rdata(o_rdata), .o_unit_clk_en(o_unit_clk_en),
        .o_unit_rstn(o_unit_rstn), .o_tx_rstn(o_tx_rstn), .o_rx_rstn(o_rx_rstn),
        .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
        .o_rx_pin_int(o_rx_pin_int), .o_state(o_state));
    // ------------------------------------------------------------
    // bus tasks; mdl mirrors the register, bit0 pinned high
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wmask <= m;
        i_wr <= 1'b1;
        if (a == AD && i_ce) mdl = (mdl & ~m) | (d & m) | 8'h01;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(a == AD ? mdl : 8'h00);
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    task automatic ctl;
        logic [1:0] st;
        st = !mdl[7] ? 2'h0 : (mdl[6] | mdl[5]) ? 2'h2 : 2'h1;
        // o_state is registered, so let one edge pass after the last write
        @(posedge i_clk);
        @(negedge i_clk);
        `CHK({o_unit_clk_en, o_unit_rstn}, {mdl[7], mdl[7]})
        `CHK({o_tx_enable, o_tx_rstn}, {2{mdl[7] & mdl[6]}})
        `CHK({o_rx_enable, o_rx_rstn}, {2{mdl[7] & mdl[5]}})
        `CHK(o_state, st)
    endtask
    // frame from the far end; with power off the pin must read high inside
    task automatic frame(input logic off);
        logic [9:0] fr;
        @(posedge i_clk);
        send <= 1'b1;
        tx_byte <= 8'($urandom);
        @(posedge i_clk);
        send <= 1'b0;
        fr = {1'b1, tx_byte, 1'b0};
        lo = 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(negedge i_clk);
            `CHK(o_rx_pin_int, off | fr[k])
            lo = lo | ~o_rx_pin_int;
        end
        if (!off) `CHK(lo, 1'b1)
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // read data stands in the enabled cycle after the strobe
    always @(posedge i_clk) begin
        pend <= i_rd & i_ce & i_rstn;
        if (pend) begin
            exp_v = exp_q.pop_front();
            `CHK(o_rdata, exp_v)
        end
    end
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        // reset edge at time zero so every register really resets
        i_rstn <= 1'b0;
        void'($urandom(77));
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(AD);
        ctl();
        wr(AD, 8'hfe, 8'hff);
        rd(AD);
        ctl();
        for (int b = 5; b < 8; b++) begin
            wr(AD, 8'h00, 8'h01 << b);
            rd(AD);
            ctl();
            wr(AD, 8'hff, 8'h01 << b);
            ctl();
        end
        wr(AD, 8'h00, 8'h80);
        frame(1'b1);
        wr(AD, 8'h80, 8'h80);
        frame(1'b0);
        wr(16'hff71, 8'h00, 8'hff);
        rd(16'hff71);
        @(posedge i_clk) i_ce <= 1'b0;
        wr(AD, 8'h00, 8'hff);
        i_ce <= 1'b1;
        rd(AD);
        repeat (8) begin
            wr(AD, 8'($urandom), 8'($urandom));
            rd(AD);
            ctl();
        end
        @(posedge i_clk) i_rstn <= 1'b0;
        mdl = 8'h01;
        ctl();
        @(posedge i_clk) i_rstn <= 1'b1;
        rd(AD);
        ctl();
        repeat (3) @(posedge i_clk);
        tally_and_finish();
    end
endmodule
